// file: hw/spp_port.sv
// Shared-pin parallel I/O port: registers, pin mux and change notification.
// Assumes synchronous pad inputs and a single-cycle register port.

`timescale 1ns/1ps
`include "spp_consts.svh"

module spp_port #(
  parameter int           W          = `SPP_PORT_W,
  parameter logic [W-1:0] IMPL_MASK  = `SPP_ALL_ONES,
  parameter logic [W-1:0] ANA_MASK   = `SPP_ALL_ONES,
  parameter logic [W-1:0] OUT_MASK   = `SPP_ALL_ONES
) (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic [`SPP_ADDR_W-1:0] addr,
  input  wire logic [W-1:0]           wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [W-1:0]           rdata,
  input  wire logic [W-1:0]           pad_in,
  output logic      [W-1:0]           pad_out,
  output logic      [W-1:0]           pad_oe_n,
  output logic      [W-1:0]           weak_pull_up,
  output logic      [W-1:0]           weak_pull_down,
  input  wire logic [W-1:0]           periph_enable,
  input  wire logic [W-1:0]           periph_out_en,
  input  wire logic [W-1:0]           periph_out_data,
  output logic      [W-1:0]           periph_in,
  output logic                        input_change_notice
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [W-1:0] pin_direction;
    logic [W-1:0] output_latch;
    logic [W-1:0] open_drain_select;
    logic [W-1:0] analog_select;
    logic [W-1:0] change_irq_enable;
    logic [W-1:0] weak_pull_up_enable;
    logic [W-1:0] weak_pull_down_enable;
    logic [W-1:0] pin_sample;
    logic [W-1:0] pad_out;
    logic [W-1:0] pad_oe_n;
    logic [W-1:0] pull_up;
    logic [W-1:0] pull_down;
    logic [W-1:0] periph_in;
    logic [W-1:0] rdata;
  } spp_state_t;

  spp_state_t       st_ff;
  spp_state_t       nxt_st;
  spp_pkg::spp_sel_t sel;
  logic [W-1:0]     mux_out;
  logic [W-1:0]     mux_oe_n;
  logic [W-1:0]     mux_periph_in;
  logic [W-1:0]     ansel_eff;
  logic [W-1:0]     pin_digital;
  logic [W-1:0]     chg_pending;
  logic [W-1:0]     chg_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  always_comb begin
    case (addr)
      `SPP_OFF_DIR:   sel = spp_pkg::SPP_SEL_DIR;
      `SPP_OFF_LATCH: sel = spp_pkg::SPP_SEL_LATCH;
      `SPP_OFF_PIN:   sel = spp_pkg::SPP_SEL_PIN;
      `SPP_OFF_ODC:   sel = spp_pkg::SPP_SEL_ODC;
      `SPP_OFF_ANSEL: sel = spp_pkg::SPP_SEL_ANSEL;
      `SPP_OFF_CNEN:  sel = spp_pkg::SPP_SEL_CNEN;
      `SPP_OFF_PU:    sel = spp_pkg::SPP_SEL_PU;
      `SPP_OFF_PD:    sel = spp_pkg::SPP_SEL_PD;
      `SPP_OFF_CHG:   sel = spp_pkg::SPP_SEL_CHG;
      default:        sel = spp_pkg::SPP_SEL_NONE;
    endcase
  end

  // Analog select only exists on analog-capable pins
  assign ansel_eff   = st_ff.analog_select & ANA_MASK;
  // Analog pins read as low everywhere digital logic looks
  assign pin_digital = st_ff.pin_sample & ~ansel_eff & IMPL_MASK;
  // Write-one-to-clear; a change in the same cycle still sets the flag
  assign chg_clear   = (wr && sel == spp_pkg::SPP_SEL_CHG) ? wdata : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexer and change detector

  spp_pin_mux #(
    .W        (W),
    .OUT_MASK (OUT_MASK)
  ) u_mux (
    .dir             (st_ff.pin_direction),
    .latch           (st_ff.output_latch),
    .odc             (st_ff.open_drain_select),
    .ansel_eff       (ansel_eff),
    .periph_enable   (periph_enable),
    .periph_out_en   (periph_out_en),
    .periph_out_data (periph_out_data),
    .pad_in          (pad_in),
    .pad_out         (mux_out),
    .pad_oe_n        (mux_oe_n),
    .periph_in       (mux_periph_in)
  );

  spp_change_det #(
    .W (W)
  ) u_chg (
    .clock     (clock),
    .nrst      (nrst),
    .pin_level (pin_digital),
    .enable    (st_ff.change_irq_enable & IMPL_MASK),
    .clear     (chg_clear),
    .pending   (chg_pending),
    .irq       (input_change_notice)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    // Pins are read through one sample stage, hence the one-cycle read lag
    nxt_st.pin_sample = pad_in & IMPL_MASK;
    nxt_st.pad_out    = mux_out & IMPL_MASK;
    nxt_st.pad_oe_n   = mux_oe_n | ~IMPL_MASK;
    nxt_st.pull_up    = st_ff.weak_pull_up_enable;
    nxt_st.pull_down  = st_ff.weak_pull_down_enable;
    nxt_st.periph_in  = mux_periph_in & IMPL_MASK;
    nxt_st.rdata      = '0;

    if (wr) begin
      case (sel)
        spp_pkg::SPP_SEL_DIR:   nxt_st.pin_direction         = wdata & IMPL_MASK;
        spp_pkg::SPP_SEL_LATCH: nxt_st.output_latch          = wdata & IMPL_MASK;
        spp_pkg::SPP_SEL_PIN:   nxt_st.output_latch          = wdata & IMPL_MASK;
        spp_pkg::SPP_SEL_ODC:   nxt_st.open_drain_select     = wdata & IMPL_MASK;
        spp_pkg::SPP_SEL_ANSEL: nxt_st.analog_select         = wdata & IMPL_MASK & ANA_MASK;
        spp_pkg::SPP_SEL_CNEN:  nxt_st.change_irq_enable     = wdata & IMPL_MASK;
        spp_pkg::SPP_SEL_PU:    nxt_st.weak_pull_up_enable   = wdata & IMPL_MASK;
        spp_pkg::SPP_SEL_PD:    nxt_st.weak_pull_down_enable = wdata & IMPL_MASK;
        default: ;
      endcase
    end

    if (rd) begin
      case (sel)
        spp_pkg::SPP_SEL_DIR:   nxt_st.rdata = st_ff.pin_direction;
        spp_pkg::SPP_SEL_LATCH: nxt_st.rdata = st_ff.output_latch;
        spp_pkg::SPP_SEL_PIN:   nxt_st.rdata = pin_digital;
        spp_pkg::SPP_SEL_ODC:   nxt_st.rdata = st_ff.open_drain_select;
        spp_pkg::SPP_SEL_ANSEL: nxt_st.rdata = st_ff.analog_select;
        spp_pkg::SPP_SEL_CNEN:  nxt_st.rdata = st_ff.change_irq_enable;
        spp_pkg::SPP_SEL_PU:    nxt_st.rdata = st_ff.weak_pull_up_enable;
        spp_pkg::SPP_SEL_PD:    nxt_st.rdata = st_ff.weak_pull_down_enable;
        spp_pkg::SPP_SEL_CHG:   nxt_st.rdata = chg_pending;
        default:                nxt_st.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff                       <= '0;
      st_ff.pin_direction         <= IMPL_MASK;
      st_ff.analog_select         <= IMPL_MASK & ANA_MASK;
      st_ff.pad_oe_n              <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata          = st_ff.rdata;
  assign pad_out        = st_ff.pad_out;
  assign pad_oe_n       = st_ff.pad_oe_n;
  assign weak_pull_up   = st_ff.pull_up;
  assign weak_pull_down = st_ff.pull_down;
  assign periph_in      = st_ff.periph_in;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic [W-1:0] own_now;
  logic [W-1:0] port_drv_now;
  assign own_now      = periph_enable & periph_out_en & OUT_MASK & IMPL_MASK;
  assign port_drv_now = ~mux_oe_n & ~own_now & IMPL_MASK;

  // Owned pins follow the peripheral, open drain included, never the latch
  property p_periph_owns;
    ($past(own_now) & ((pad_oe_n ^ $past(periph_out_data & st_ff.open_drain_select))
      | (pad_out ^ $past(periph_out_data & ~st_ff.open_drain_select)))) == '0;
  endproperty
  a_periph_owns: assert property (p_periph_owns)
    else $error("Peripheral drive did not own the pin");

  property p_idle_periph;
    ($past(periph_enable & ~periph_out_en & ~st_ff.pin_direction & ~st_ff.open_drain_select & IMPL_MASK)
      & pad_oe_n) == '0;
  endproperty
  a_idle_periph: assert property (p_idle_periph)
    else $error("Port failed to drive pin beside idle peripheral");

  property p_no_loop;
    (periph_in & $past(port_drv_now)) == '0;
  endproperty
  a_no_loop: assert property (p_no_loop)
    else $error("Port drive looped into peripheral input");

  property p_dir_input;
    ($past(st_ff.pin_direction & ~own_now) & ~pad_oe_n) == '0;
  endproperty
  a_dir_input: assert property (p_dir_input)
    else $error("Input pin was driven");

  property p_reset_dir;
    $past(!nrst) |-> (st_ff.pin_direction == IMPL_MASK) && (pad_oe_n == '1);
  endproperty
  a_reset_dir: assert property (p_reset_dir)
    else $error("Pins not inputs after reset");

  property p_pin_write;
    (wr && addr == `SPP_OFF_PIN) |=> st_ff.output_latch == ($past(wdata) & IMPL_MASK);
  endproperty
  a_pin_write: assert property (p_pin_write)
    else $error("Pin write did not reach latch");

  property p_latch_read;
    (rd && addr == `SPP_OFF_LATCH && !wr) |=> rdata == $past(st_ff.output_latch);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("Latch read returned wrong value");

  property p_unimpl_zero;
    ((st_ff.output_latch | st_ff.pin_direction | rdata) & ~IMPL_MASK) == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("Unimplemented bit not zero");

  property p_open_drain;
    ($past(st_ff.open_drain_select) & pad_out) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Open-drain pin drove high");

  property p_analog_read;
    (rd && addr == `SPP_OFF_PIN) |=> (rdata & $past(ansel_eff)) == '0;
  endproperty
  a_analog_read: assert property (p_analog_read)
    else $error("Analog pin read nonzero");

  property p_change_irq;
    ((pin_digital ^ $past(pin_digital)) & $past(st_ff.change_irq_enable) & st_ff.change_irq_enable) != '0
      |-> ##1 input_change_notice;
  endproperty
  a_change_irq: assert property (p_change_irq)
    else $error("Enabled pin change raised no request");

  property p_cn_quiet;
    (st_ff.change_irq_enable == '0 && chg_pending == '0) |=> chg_pending == '0;
  endproperty
  a_cn_quiet: assert property (p_cn_quiet)
    else $error("Disabled pin raised change flag");

  // Analog after reset keeps floating pads out of digital input buffers
  property p_reset_ansel;
    $past(!nrst) |-> st_ff.analog_select == (IMPL_MASK & ANA_MASK);
  endproperty
  a_reset_ansel: assert property (p_reset_ansel)
    else $error("Analog select not all ones after reset");

  property p_analog_periph;
    ($past(ansel_eff) & periph_in) == '0;
  endproperty
  a_analog_periph: assert property (p_analog_periph)
    else $error("Analog pin reached a digital peripheral");

  property p_analog_drive;
    ($past(ansel_eff & ~st_ff.pin_direction & ~st_ff.open_drain_select & ~own_now) & pad_oe_n) == '0;
  endproperty
  a_analog_drive: assert property (p_analog_drive)
    else $error("Analog output pin was not driven");

  property p_dir_output;
    ($past(~st_ff.pin_direction & ~st_ff.open_drain_select & ~own_now & IMPL_MASK)
      & (pad_oe_n | (pad_out ^ $past(st_ff.output_latch)))) == '0;
  endproperty
  a_dir_output: assert property (p_dir_output)
    else $error("Output pin did not drive its latch");

  property p_pin_read;
    (rd && addr == `SPP_OFF_PIN) |=> rdata == $past(st_ff.pin_sample & ~ansel_eff);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("Pin read did not return sampled pins");

  property p_pulls;
    weak_pull_up == $past(st_ff.weak_pull_up_enable) && weak_pull_down == $past(st_ff.weak_pull_down_enable);
  endproperty
  a_pulls: assert property (p_pulls)
    else $error("Weak pull did not follow its enable");

  // A claim by an input-only function must not take the driver from the port
  property p_input_only;
    ($past(periph_enable & periph_out_en & ~OUT_MASK & IMPL_MASK
      & ~st_ff.pin_direction & ~st_ff.open_drain_select)
      & (pad_oe_n | (pad_out ^ $past(st_ff.output_latch)))) == '0;
  endproperty
  a_input_only: assert property (p_input_only)
    else $error("Input-only sharing took the port driver");

  // Two-deep history: the flag lands one edge after the sample that differs
  property p_change_flag;
    (~chg_pending & ($past(pin_digital) ^ $past(pin_digital, 2))
      & $past(st_ff.change_irq_enable & IMPL_MASK)) == '0;
  endproperty
  a_change_flag: assert property (p_change_flag)
    else $error("Enabled pin difference left no pending flag");

  c_pin_read:    cover property ((rd && addr == `SPP_OFF_PIN) ##1 (rdata != '0));
  c_change_irq:  cover property ($rose(input_change_notice));
  c_periph_take: cover property ((own_now != '0) ##1 (pad_oe_n != '1));
  c_analog_out:  cover property ((ansel_eff & ~st_ff.pin_direction) != '0);

endmodule // spp_port

// file: hw/spp_consts.svh
// Offsets, mask constants and widths of the shared-pin parallel port.
// Assumes a byte-addressed register port, one register per offset, offsets 4 apart.
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

`define SPP_PORT_W     16
`define SPP_ADDR_W     6

`define SPP_OFF_DIR    6'h00
`define SPP_OFF_LATCH  6'h04
`define SPP_OFF_PIN    6'h08
`define SPP_OFF_ODC    6'h0C
`define SPP_OFF_ANSEL  6'h10
`define SPP_OFF_CNEN   6'h14
`define SPP_OFF_PU     6'h18
`define SPP_OFF_PD     6'h1C
`define SPP_OFF_CHG    6'h20

`define SPP_ALL_ONES   16'hFFFF
`define SPP_ALL_ZERO   16'h0000

`endif

// file: hw/spp_pkg.sv
// Shared types of the shared-pin parallel port.
// Assumes nothing beyond the constants header.
package spp_pkg;

  typedef enum logic [3:0] {
    SPP_SEL_DIR,
    SPP_SEL_LATCH,
    SPP_SEL_PIN,
    SPP_SEL_ODC,
    SPP_SEL_ANSEL,
    SPP_SEL_CNEN,
    SPP_SEL_PU,
    SPP_SEL_PD,
    SPP_SEL_CHG,
    SPP_SEL_NONE
  } spp_sel_t;

endpackage

// file: hw/spp_pin_mux.sv
// Per-pin output multiplexer between port and peripheral, plus input gating.
// Assumes all inputs are registered values of the same clock domain.
`timescale 1ns/1ps
module spp_pin_mux #(
  parameter int             W         = 16,
  parameter logic [W-1:0]   OUT_MASK  = '1
) (
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] odc,
  input  wire logic [W-1:0] ansel_eff,
  input  wire logic [W-1:0] periph_enable,
  input  wire logic [W-1:0] periph_out_en,
  input  wire logic [W-1:0] periph_out_data,
  input  wire logic [W-1:0] pad_in,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe_n,
  output logic      [W-1:0] periph_in
);
  for (genvar i = 0; i < W; i++) begin : g_pin
    logic own;
    logic src_data;
    logic src_oe;
    logic drive;
    // Input-only sharing never takes the driver away from the port
    assign own       = periph_enable[i] & periph_out_en[i] & OUT_MASK[i];
    assign src_data  = own ? periph_out_data[i] : latch[i];
    assign src_oe    = own | ~dir[i];
    // Open drain: only the low level is ever driven
    assign drive     = src_oe & (~odc[i] | ~src_data);
    assign pad_out[i]  = src_data & ~odc[i];
    assign pad_oe_n[i] = ~drive;
    // Peripheral never hears the port's own drive
    assign periph_in[i] = pad_in[i] & ~ansel_eff[i] & ~(drive & ~own);
  end
endmodule // spp_pin_mux

// file: hw/spp_change_det.sv
// Change-of-state detector with sticky pending flags and one request line.
// Assumes pin levels arrive registered; clear is a one-cycle write.
`timescale 1ns/1ps
module spp_change_det #(
  parameter int W = 16
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin_level,
  input  wire logic [W-1:0] enable,
  input  wire logic [W-1:0] clear,
  output logic      [W-1:0] pending,
  output logic              irq
);
  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] pending;
    logic         irq;
  } spp_cn_state_t;

  spp_cn_state_t st_ff;
  spp_cn_state_t nxt_st;
  logic [W-1:0]  change_of_state;

  always_comb begin
    // Previous level is held while the clock is stopped, so a change in
    // sleep still shows as a difference on the first edge after wake.
    change_of_state = (pin_level ^ st_ff.prev) & enable;
    nxt_st          = st_ff;
    nxt_st.prev     = pin_level;
    nxt_st.pending  = (st_ff.pending & ~clear) | change_of_state;
    nxt_st.irq      = |nxt_st.pending;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pending = st_ff.pending;
  assign irq     = st_ff.irq;
endmodule // spp_change_det

// file: tb/spp_board.sv
// Board model: resolves each pad from the port, an external driver and the pulls.
// Assumes the bench enables the external driver only on pins the port leaves free.
`timescale 1ns/1ps
module spp_board #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] pad_oe_n,
  input  wire logic [W-1:0] weak_pull_up,
  input  wire logic [W-1:0] weak_pull_down,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] pad_in
);
  ////////////////////////////////////////////////////////////
  // A floating pin shows the inverse of the port data, never a held value
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (weak_pull_up[i]) pad_in[i] = 1'b1;
      else if (weak_pull_down[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~pad_out[i];
    end
  end
endmodule // spp_board

// file: tb/spp_port_tb.sv
// Self-checking bench of the shared-pin port: register port, pin mux, change notice.
// Assumes the board model on the pads and a single 200 MHz clock.
`timescale 1ns/1ps
`include "spp_consts.svh"
module spp_port_tb;
  localparam logic [15:0] IMPL = 16'h7FFF;
  localparam logic [15:0] ANA  = 16'h00FF;
  localparam logic [15:0] OUTM = 16'hFFFE;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata, pad_in, pad_out, pad_oe_n, pu, pd, pin;
  logic [15:0] pen = 16'h0000;
  logic [15:0] poe = 16'h0000;
  logic [15:0] pdat = 16'h0000;
  logic [15:0] ext_en = 16'h0000;
  logic [15:0] ext_val = 16'h0000;
  logic        irq;
  logic        rd_seen = 1'b0;
  logic [15:0] d;
  logic [15:0] expq[$];
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int unsigned rv;

  spp_port #(.W(16), .IMPL_MASK(IMPL), .ANA_MASK(ANA), .OUT_MASK(OUTM)) u_dut (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .weak_pull_up(pu), .weak_pull_down(pd), .periph_enable(pen),
    .periph_out_en(poe), .periph_out_data(pdat), .periph_in(pin),
    .input_change_notice(irq));
  spp_board #(.W(16)) u_board (
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .weak_pull_up(pu),
    .weak_pull_down(pd), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  always #2.5 clock = ~clock;

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Strobes stay up until the next call, so back-to-back cycles need no gap
  task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [15:0] v);
    @(posedge clock);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= v;
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 6'h00, 16'h0000);
  endtask
  task automatic wreg(input logic [5:0] a, input logic [15:0] v);
    bus(1'b1, 1'b0, a, v);
  endtask
  task automatic rreg(input logic [5:0] a, input logic [15:0] x);
    expq.push_back(x);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clock) rd_seen <= rd;
  always @(negedge clock) if (rd_seen) chk(rdata, expq.pop_front());
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    rv = $urandom(32'hdf92);
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    idle(1);
    rreg(`SPP_OFF_DIR, IMPL);
    rreg(`SPP_OFF_ANSEL, IMPL & ANA);
    rreg(6'h3C, 16'h0000);
    #1;
    chk(pad_oe_n, 16'hFFFF);
    rv = $urandom;
    d = rv[15:0];
    wreg(`SPP_OFF_LATCH, d);
    rreg(`SPP_OFF_LATCH, d & IMPL);
    wreg(`SPP_OFF_DIR, 16'hFFFF);
    rreg(`SPP_OFF_DIR, IMPL);
    wreg(`SPP_OFF_PIN, ~d);
    rreg(`SPP_OFF_LATCH, ~d & IMPL);
    // Digital pins: 7:4 outputs, the rest inputs driven by the board
    wreg(`SPP_OFF_ANSEL, 16'h0000);
    wreg(`SPP_OFF_LATCH, 16'h005A);
    wreg(`SPP_OFF_DIR, 16'hFF0F);
    ext_en <= 16'hFF0F;
    ext_val <= 16'hC305;
    idle(2);
    rreg(`SPP_OFF_PIN, 16'h4355);
    #1;
    chk(pad_oe_n, 16'hFF0F);
    chk(pad_out, 16'h005A);
    chk(pin & IMPL, 16'h4305);
    wreg(`SPP_OFF_ANSEL, 16'hFFFF);
    idle(2);
    rreg(`SPP_OFF_PIN, 16'h4300);
    #1;
    chk(pad_oe_n, 16'hFF0F);
    chk(pin & IMPL, 16'h4300);
    wreg(`SPP_OFF_ODC, 16'h0030);
    idle(2);
    #1;
    chk(pad_oe_n, 16'hFF1F);
    chk(pad_out, 16'h004A);
    // Peripherals on bits 0, 2, 4 and 6; bit 0 is input-only sharing
    wreg(`SPP_OFF_ODC, 16'h0000);
    wreg(`SPP_OFF_ANSEL, 16'h0000);
    wreg(`SPP_OFF_DIR, 16'hFF0E);
    ext_en <= 16'hFF00;
    pen <= 16'h0055;
    poe <= 16'h0045;
    pdat <= 16'h0005;
    idle(2);
    rreg(`SPP_OFF_PIN, 16'h4314);
    #1;
    chk(pad_oe_n, 16'hFF0A);
    chk(pad_out, 16'h001E);
    chk(pin & IMPL, 16'h4304);
    wreg(`SPP_OFF_PU, 16'h1234);
    wreg(`SPP_OFF_PD, 16'h8421);
    rreg(`SPP_OFF_PU, 16'h1234);
    idle(1);
    #1;
    chk(pu, 16'h1234);
    chk(pd, 16'h0421);
    wreg(`SPP_OFF_PU, 16'h0000);
    wreg(`SPP_OFF_PD, 16'h0000);
    // Change notice on bit 8 only
    wreg(`SPP_OFF_CNEN, 16'h0100);
    wreg(`SPP_OFF_CHG, 16'hFFFF);
    idle(2);
    ext_val <= ext_val ^ 16'h0200;
    idle(3);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    ext_val <= ext_val ^ 16'h0100;
    idle(3);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    rreg(`SPP_OFF_CHG, 16'h0100);
    wreg(`SPP_OFF_CHG, 16'h0100);
    idle(2);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    idle(2);
    end_sim();
  end
endmodule // spp_port_tb
